// >>> bench/slca_remote.sv
`timescale 1ns/1ps
// Remote async station: drives frames into the port, decodes what it sends
module slca_remote #(
  parameter int BIT_CLKS = 64
) (
  // Clock
  input  wire logic       i_clk,
  // Line from the port, line into the port
  input  wire logic       i_line,
  output logic            o_line,
  // Last decoded frame and frame count
  output logic [8:0]      o_got,
  output logic [7:0]      o_cnt
);
  logic       line_r = 1'b1;
  logic [8:0] got_r  = 9'h000;
  logic [7:0] cnt_r  = 8'h00;
  // Line rests at mark level between frames, as a pulled-up pin would
  assign o_line = line_r;
  assign o_got  = got_r;
  assign o_cnt  = cnt_r;
  // Start, eight data LSB first, ninth or stop, then stop
  task automatic send(input logic [8:0] f);
    logic [10:0] w;
    w = {1'b1, f, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge i_clk);
      line_r <= w[i];
      repeat (BIT_CLKS - 1) @(posedge i_clk);
    end
  endtask
  // Mid-bit sampling; short frames put their stop bit in the ninth slot
  always begin
    @(negedge i_line);
    repeat (BIT_CLKS / 2) @(posedge i_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CLKS) @(posedge i_clk);
      got_r[i] = i_line;
    end
    cnt_r = cnt_r + 8'h01;
  end
endmodule

// >>> bench/slca_uart_properties.sv
`timescale 1ns/1ps
`include "slca_defs.svh"
module slca_uart_properties (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  // Bus and pins of the port
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [9:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  input  wire logic [31:0] O_WB_DAT,
  input  wire logic        O_WB_ACK,
  input  wire logic        O_RXD_OE,
  input  wire logic        O_TXD,
  input  wire logic        O_IRQ
);
  logic        take;
  logic        wr;
  logic [2:0]  mode_r;
  logic        ea_r;
  logic        fesel_r;
  logic        ea_q;
  logic        sent_r;
  logic        txd_q;
  logic [15:0] run_r;
  // Requests the slave takes; writes only count with the low byte lane
  assign take = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  assign wr   = take && I_WB_WE && I_WB_SEL[0];
  // Shadows of mode and global enable, and run length of the line level
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      mode_r <= 3'h0;
      ea_r   <= 1'b0;
      fesel_r <= 1'b0;
      ea_q   <= 1'b0;
      sent_r <= 1'b0;
      txd_q  <= 1'b1;
      run_r  <= 16'h0000;
    end else begin
      if (wr && I_WB_ADR[9:2] == `SLCA_IDX_CTRL)
        mode_r <= {fesel_r ? mode_r[2] : I_WB_DAT[`SLCA_B_MODE_HI], I_WB_DAT[`SLCA_B_MODE_LO], I_WB_DAT[`SLCA_B_MPE]};
      // The top control bit is the framing flag while the select is set
      if (wr && I_WB_ADR[9:2] == `SLCA_IDX_AUX)
        fesel_r <= I_WB_DAT[`SLCA_B_FESEL];
      if (wr && I_WB_ADR[9:2] == `SLCA_IDX_IEN)
        ea_r <= I_WB_DAT[`SLCA_B_EA];
      ea_q   <= ea_r;
      sent_r <= sent_r | (wr && I_WB_ADR[9:2] == `SLCA_IDX_DATA);
      txd_q  <= O_TXD;
      run_r  <= (O_TXD != txd_q) ? 16'h0001 : run_r + 16'h0001;
    end
  end
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  ack_lat_a: assert property (take |=> O_WB_ACK)
    else $error("no ack one cycle after request");
  ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held past one cycle");
  rdat_high_a: assert property (O_WB_ACK |-> O_WB_DAT[31:8] == 24'h000000)
    else $error("upper read data not zero");
  irq_gate_a: assert property (!ea_r && !ea_q |-> !O_IRQ)
    else $error("irq without global enable");
  txd_idle_a: assert property (!sent_r |-> O_TXD)
    else $error("line left idle before any send");
  tx_start_a: assert property (wr && I_WB_ADR[9:2] == `SLCA_IDX_DATA |-> ##[1:8] !O_TXD)
    else $error("frame not started after buffer write");
  bit_len_a: assert property ($rose(O_TXD) && mode_r[2:1] == 2'b10 |-> run_r[5:0] == 6'h00)
    else $error("low run not whole 64 clock bits");
  shift_half_a: assert property ($fell(O_TXD) && mode_r == 3'b001 |-> ##1 !O_TXD ##1 O_TXD)
    else $error("fast shift clock half not 2 clocks");
  oe_mode_a: assert property (O_RXD_OE |-> mode_r[2:1] == 2'b00)
    else $error("data pin driven outside shift mode");
  tx_frame_c: cover property ($rose(O_TXD) && mode_r[2:1] == 2'b10);
  irq_c: cover property ($rose(O_IRQ));
  shift_c: cover property (O_RXD_OE && !O_TXD);
endmodule
bind slca_uart slca_uart_properties u_props (.I_CLK, .I_RST_N, .I_WB_CYC, .I_WB_STB, .I_WB_WE, .I_WB_ADR,
  .I_WB_SEL, .I_WB_DAT, .O_WB_DAT, .O_WB_ACK, .O_RXD_OE, .O_TXD, .O_IRQ);

// >>> bench/tb_slca_uart.sv
`timescale 1ns/1ps
`include "slca_defs.svh"
module tb_slca_uart;
  logic        rst_n, cyc, stb, we, ack, rxd, rxd_oe, txd, irq, line, pin, oe;
  logic        clk  = 1'b0;
  logic        tick = 1'b0;
  logic [3:0]  sel, lane;
  logic [9:0]  adr;
  logic [31:0] wdat, rdat;
  logic [8:0]  got;
  logic [7:0]  cnt, sh, d;
  logic [1:0]  tdiv = 2'h0;
  int          fail_count, num_checks;
  slca_uart dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_BAUD_TICK(tick), .I_RXD(pin), .O_RXD(rxd), .O_RXD_OE(rxd_oe), .O_TXD(txd), .O_IRQ(irq)
  );
  slca_remote rm (.i_clk(clk), .i_line(txd), .o_line(line), .o_got(got), .o_cnt(cnt));
  // Shared data wire: the port wins while it drives in shift mode
  assign pin = rxd_oe ? rxd : line;
  always #5 clk = ~clk;
  // Baud strobe every 4 clocks gives 64 clock bits in modes 1 and 3
  always @(posedge clk) begin
    tdiv <= tdiv + 2'h1;
    tick <= (tdiv == 2'h3);
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One classic cycle; request held until ack is seen
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] v, output logic [7:0] q);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= lane;
    adr  <= {idx, 2'b00};
    wdat <= {24'h000000, v};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    bus(1'b1, idx, v, d);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00, d);
    chk(d, e);
  endtask
  // Irq is registered, so let two edges land first
  task automatic irqc(input logic [7:0] e);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, e);
  endtask
  // Partner decodes at mid ninth bit; then rest of it, stop bit and idle
  task automatic wait_frame;
    logic [7:0] c0;
    c0 = cnt;
    for (int i = 0; i < 2000 && cnt == c0; i++) @(posedge clk);
    repeat (100) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog well past the roughly 6000 clocks the tests need
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    wrap_up;
  end
  initial begin
    {rst_n, cyc, stb, we, sel, adr, wdat} = '0;
    lane = 4'h1;
    fail_count = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`SLCA_IDX_CTRL, 8'h00);
    rdc(`SLCA_IDX_SMASK, 8'h00);
    wr(`SLCA_IDX_STATION_ADDRESS, 8'h5A);
    rdc(`SLCA_IDX_STATION_ADDRESS, 8'h5A);
    // A write without the low byte lane is acknowledged but dropped
    lane = 4'hE;
    wr(`SLCA_IDX_STATION_ADDRESS, 8'hC3);
    lane = 4'h1;
    rdc(`SLCA_IDX_STATION_ADDRESS, 8'h5A);
    rdc(8'h00, 8'h00);
    $display("registers done");
    // Both 11-bit modes; ninth bit set only in mode 3
    for (int m = 2; m < 4; m++) begin
      wr(`SLCA_IDX_CTRL, {m[1:0], 2'b00, m[0], 3'b000});
      wr(`SLCA_IDX_DATA, m[0] ? 8'h3C : 8'hA5);
      wait_frame;
      chk(got[7:0], m[0] ? 8'h3C : 8'hA5);
      chk({7'h00, got[8]}, {7'h00, m[0]});
      rdc(`SLCA_IDX_CTRL, {m[1:0], 2'b00, m[0], 3'b010});
      rdc(`SLCA_IDX_DATA, 8'h00);
    end
    wr(`SLCA_IDX_IEN, 8'h10);
    irqc(8'h00);
    wr(`SLCA_IDX_IEN, 8'h80);
    irqc(8'h00);
    wr(`SLCA_IDX_IEN, 8'h90);
    irqc(8'h01);
    wr(`SLCA_IDX_CTRL, 8'hC8);
    irqc(8'h00);
    $display("transmit done");
    // Multiprocessor receive with masked address match
    wr(`SLCA_IDX_SMASK, 8'hF0);
    wr(`SLCA_IDX_CTRL, 8'hB0);
    rm.send(9'h033);
    rdc(`SLCA_IDX_CTRL, 8'hB0);
    wr(`SLCA_IDX_EVCLR, 8'h0F);
    rm.send(9'h15C);
    rdc(`SLCA_IDX_CTRL, 8'hB5);
    rdc(`SLCA_IDX_DATA, 8'h5C);
    rdc(`SLCA_IDX_EVST, 8'h09);
    wr(`SLCA_IDX_IEN, 8'h80);
    wr(`SLCA_IDX_EVEN, 8'h08);
    irqc(8'h01);
    wr(`SLCA_IDX_EVEN, 8'h00);
    irqc(8'h00);
    wr(`SLCA_IDX_EVEN, 8'h08);
    irqc(8'h01);
    wr(`SLCA_IDX_EVCLR, 8'h08);
    irqc(8'h00);
    wr(`SLCA_IDX_CTRL, 8'hB0);
    rm.send(9'h13C);
    rdc(`SLCA_IDX_EVST, 8'h01);
    wr(`SLCA_IDX_CTRL, 8'h80);
    rm.send(9'h111);
    rdc(`SLCA_IDX_CTRL, 8'h80);
    rdc(`SLCA_IDX_DATA, 8'h5C);
    $display("receive done");
    // 10-bit frames: bad stop suppressed, good stop kept as ninth
    wr(`SLCA_IDX_EVCLR, 8'h0F);
    wr(`SLCA_IDX_CTRL, 8'h70);
    rm.send(9'h077);
    rdc(`SLCA_IDX_CTRL, 8'h70);
    rdc(`SLCA_IDX_EVST, 8'h04);
    wr(`SLCA_IDX_CTRL, 8'h50);
    rm.send(9'h166);
    rdc(`SLCA_IDX_CTRL, 8'h55);
    rdc(`SLCA_IDX_DATA, 8'h66);
    rdc(`SLCA_IDX_EVST, 8'h05);
    // Framing flag shown in the top control bit stays until software clears it
    wr(`SLCA_IDX_AUX, 8'h01);
    rdc(`SLCA_IDX_AUX, 8'h01);
    rdc(`SLCA_IDX_CTRL, 8'hD5);
    wr(`SLCA_IDX_CTRL, 8'h55);
    rdc(`SLCA_IDX_CTRL, 8'h55);
    wr(`SLCA_IDX_AUX, 8'h00);
    $display("short frames done");
    // Shift mode last: its clock on the line upsets the remote decoder
    wr(`SLCA_IDX_CTRL, 8'h20);
    wr(`SLCA_IDX_DATA, 8'h96);
    oe = 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge txd);
      sh[i] = rxd;
      oe = oe & rxd_oe;
    end
    chk(sh, 8'h96);
    chk({7'h00, oe}, 8'h01);
    repeat (4) @(posedge clk);
    rdc(`SLCA_IDX_CTRL, 8'h22);
    $display("shift mode done");
    wrap_up;
  end
endmodule

// >>> hdl/slca_defs.svh
`ifndef SLCA_DEFS_SVH
`define SLCA_DEFS_SVH

// Register word indexes, byte address is four times the index
`define SLCA_IDX_CTRL  8'h98
`define SLCA_IDX_DATA  8'h99
`define SLCA_IDX_IEN   8'hA8
`define SLCA_IDX_STATION_ADDRESS 8'hA9
`define SLCA_IDX_SMASK 8'hB9
`define SLCA_IDX_AUX   8'hC0
`define SLCA_IDX_EVST  8'hC1
`define SLCA_IDX_EVEN  8'hC2
`define SLCA_IDX_EVCLR 8'hC3

// Serial control fields
`define SLCA_B_MODE_HI 7
`define SLCA_B_MODE_LO 6
`define SLCA_B_MPE     5
`define SLCA_B_REN     4
`define SLCA_B_TB8     3
`define SLCA_B_RB8     2
`define SLCA_B_TI      1
`define SLCA_B_RI      0

// Interrupt enable and auxiliary control fields
`define SLCA_B_EA      7
`define SLCA_B_ES      4
`define SLCA_B_FESEL   0
`define SLCA_B_DBL     1

// Event status bits
`define SLCA_EV_RX     0
`define SLCA_EV_TX     1
`define SLCA_EV_FE     2
`define SLCA_EV_ADR    3

// Reset value of every byte register
`define SLCA_RST_BYTE  8'h00

// Timing in oscillator clocks per bit, and oversampling factor
`define SLCA_OVS       16
`define SLCA_M0_SLOW   12
`define SLCA_M0_FAST   4
`define SLCA_M2_SLOW   64
`define SLCA_M2_FAST   32
`define SLCA_LIM_M0S   (`SLCA_M0_SLOW / 2)
`define SLCA_LIM_M0F   (`SLCA_M0_FAST / 2)
`define SLCA_LIM_M2S   (`SLCA_M2_SLOW / `SLCA_OVS)
`define SLCA_LIM_M2F   (`SLCA_M2_FAST / `SLCA_OVS)

`endif

// >>> hdl/slca_pkg.sv
package slca_pkg;

  typedef enum logic [1:0] {SLCA_TX_IDLE, SLCA_TX_ASYNC, SLCA_TX_SYNC} slca_tx_st_t;
  typedef enum logic {SLCA_RX_IDLE, SLCA_RX_RUN} slca_rx_st_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } slca_tick_t;

  typedef struct packed {
    logic        sm0;
    logic        sm1;
    logic        sm2;
    logic        ren;
    logic        tb8;
    logic        rb8;
    logic        ti;
    logic        ri;
    logic        fe;
    logic        fe_sel;
    logic        dbl;
    logic        es;
    logic        ea;
    logic [7:0]  tx_buf;
    logic [7:0]  rx_buf;
    logic [7:0]  station_address;
    logic [7:0]  smask;
    logic [3:0]  evt_st;
    logic [3:0]  evt_en;
    logic        ack;
    logic [7:0]  rdat;
    logic        irq;
    slca_tx_st_t tx_st;
    logic [10:0] tx_sh;
    logic [3:0]  tx_bit;
    logic [3:0]  tx_tick;
    logic        tx_pend;
    logic        m0_rx;
    logic        sc;
    logic        txd;
    logic        rxd_o;
    logic        rxd_oe;
    slca_rx_st_t rx_st;
    logic [8:0]  rx_sh;
    logic [3:0]  rx_bit;
    logic [3:0]  rx_tick;
    logic        rxd_prev;
  } slca_state_t;

endpackage

// >>> hdl/slca_tick.sv
`timescale 1ns/1ps
`include "slca_defs.svh"

// Bit timing strobe: half shift-clock in mode 0, sixteenth of a bit otherwise
module slca_tick (
  // Clock and reset
  input  wire logic I_CLK,
  input  wire logic I_RST_N,
  // Mode and rate selection
  input  wire logic i_mode_hi,
  input  wire logic i_mode_lo,
  input  wire logic i_mpe,
  input  wire logic i_dbl,
  input  wire logic i_baud_tick,
  // Strobe
  output logic      o_tick
);
  import slca_pkg::*;

  slca_tick_t t_r;
  slca_tick_t t_nxt;
  logic [3:0] lim;

  // Divider limit per mode
  always_comb begin
    if (!i_mode_hi)
      lim = i_mpe ? 4'(`SLCA_LIM_M0F) : 4'(`SLCA_LIM_M0S); // [RL4]
    else
      lim = i_dbl ? 4'(`SLCA_LIM_M2F) : 4'(`SLCA_LIM_M2S); // [RL1]
  end

  // Variable-rate modes follow the external baud strobe, the others divide the clock
  always_comb begin
    t_nxt = t_r;
    t_nxt.tick = 1'b0;
    if (i_mode_lo) begin
      t_nxt.cnt  = 4'h0;
      t_nxt.tick = i_baud_tick; // [RL1]
    end else if (t_r.cnt >= lim - 4'h1) begin
      t_nxt.cnt  = 4'h0;
      t_nxt.tick = 1'b1;
    end else begin
      t_nxt.cnt = t_r.cnt + 4'h1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N)
      t_r <= '0;
    else
      t_r <= t_nxt;
  end

  assign o_tick = t_r.tick;

endmodule

// >>> hdl/slca_uart.sv
//  Contract
// RL1 - Mode bits select shift, 10-bit, 11-bit frames
// RL2 - 11-bit mode, multiproc on: ninth zero, no flag
// RL3 - 10-bit mode, multiproc on: bad stop, no flag
// RL4 - Shift mode: multiproc bit picks /12 or /4
// RL5 - Receive only while receive enable is set
// RL6 - 11-bit frames send software ninth bit unchanged
// RL7 - Received ninth bit or stop bit kept; in 10-bit mode the stop bit is kept here only with multiproc off
// RL8 - Transmit done flag timing, software clears it
// RL9 - Receive done flag timing, software clears it
// RL10 - Data location: separate receive and transmit registers
// RL11 - Software loads station address before matching
// RL12 - Masked address compare, zero mask matches all
// RL13 - Irq needs serial and global enables; event-status irqs here need the global enable and their own event enable, not the serial enable
// RL14 - Framing error flag sticky until software clears
// RL15 - Buffer write sends frame; irq ORs flags
// RL16 - Shift mode clocks on transmit pin, LSB first
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`include "slca_defs.svh"

module slca_uart (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  // Wishbone slave
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [9:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  // Serial line
  input  wire logic        I_BAUD_TICK,
  input  wire logic        I_RXD,
  output logic             O_RXD,
  output logic             O_RXD_OE,
  output logic             O_TXD,
  // Interrupt
  output logic             O_IRQ
);
  import slca_pkg::*;

  slca_state_t s_r;
  slca_state_t s_nxt;
  logic        tick;
  logic        req;
  logic        wr;
  logic [7:0]  idx;
  logic [7:0]  wd;
  logic        m0;
  logic        m23;
  logic [3:0]  last_bit;
  logic [7:0]  rx_data;
  logic        rx_ninth;
  logic        adr_ok;
  logic        rx_ok;

  // Masked compare; a zero mask makes every address match
  function automatic logic addr_match(input logic [7:0] d, input logic [7:0] a, input logic [7:0] m);
    return ((d ^ a) & m) == 8'h00;
  endfunction

  // Register index decode, shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  slca_tick u_tick (
    .I_CLK       (I_CLK),
    .I_RST_N     (I_RST_N),
    .i_mode_hi   (s_r.sm0),
    .i_mode_lo   (s_r.sm1),
    .i_mpe       (s_r.sm2),
    .i_dbl       (s_r.dbl),
    .i_baud_tick (I_BAUD_TICK),
    .o_tick      (tick)
  );

  // Bus request decode; ack is high for one cycle so each access is taken once
  assign req = I_WB_CYC & I_WB_STB & ~s_r.ack;
  assign wr  = req & I_WB_WE & I_WB_SEL[0];
  assign idx = I_WB_ADR[9:2];
  assign wd  = I_WB_DAT[7:0];

  // Frame format from the mode bits
  assign m0       = ~s_r.sm0 & ~s_r.sm1;     // [RL1]
  assign m23      = s_r.sm0;                 // [RL1]
  assign last_bit = m23 ? 4'd10 : 4'd9;      // [RL1]

  // Received fields and acceptance
  assign rx_data  = m23 ? s_r.rx_sh[7:0] : s_r.rx_sh[8:1];
  assign rx_ninth = m23 ? s_r.rx_sh[8] : I_RXD;
  assign adr_ok   = addr_match(rx_data, s_r.station_address, s_r.smask); // [RL12]
  // Multiproc gating: ninth bit and address in 11-bit modes, stop bit in 10-bit mode
  assign rx_ok = ~s_r.ri & (m23 ? (~s_r.sm2 | (rx_ninth & adr_ok)) // [RL2]
                                : (~s_r.sm2 | I_RXD));             // [RL3]

  always_comb begin
    logic [3:0] ev;
    logic [7:0] rd;
    ev    = 4'h0;
    rd    = 8'h00;
    s_nxt = s_r;
    s_nxt.ack = req;
    s_nxt.rxd_prev = I_RXD;

    // Register reads; none of them has a side effect
    if (hit(idx, `SLCA_IDX_CTRL)) begin
      rd[`SLCA_B_MODE_HI] = s_r.fe_sel ? s_r.fe : s_r.sm0;
      rd[`SLCA_B_MODE_LO] = s_r.sm1;
      rd[`SLCA_B_MPE]     = s_r.sm2;
      rd[`SLCA_B_REN]     = s_r.ren;
      rd[`SLCA_B_TB8]     = s_r.tb8;
      rd[`SLCA_B_RB8]     = s_r.rb8;
      rd[`SLCA_B_TI]      = s_r.ti;
      rd[`SLCA_B_RI]      = s_r.ri;
    end else if (hit(idx, `SLCA_IDX_DATA)) begin
      rd = s_r.rx_buf; // [RL10]
    end else if (hit(idx, `SLCA_IDX_IEN)) begin
      rd[`SLCA_B_EA] = s_r.ea;
      rd[`SLCA_B_ES] = s_r.es;
    end else if (hit(idx, `SLCA_IDX_STATION_ADDRESS)) begin
      rd = s_r.station_address;
    end else if (hit(idx, `SLCA_IDX_SMASK)) begin
      rd = s_r.smask;
    end else if (hit(idx, `SLCA_IDX_AUX)) begin
      rd[`SLCA_B_FESEL] = s_r.fe_sel;
      rd[`SLCA_B_DBL]   = s_r.dbl;
    end else if (hit(idx, `SLCA_IDX_EVST)) begin
      rd[3:0] = s_r.evt_st;
    end else if (hit(idx, `SLCA_IDX_EVEN)) begin
      rd[3:0] = s_r.evt_en;
    end
    s_nxt.rdat = req ? rd : s_r.rdat;

    // Register writes come first so that hardware sets below win over clears
    if (wr) begin
      if (hit(idx, `SLCA_IDX_CTRL)) begin
        if (s_r.fe_sel)
          s_nxt.fe = wd[`SLCA_B_MODE_HI]; // [RL14]
        else
          s_nxt.sm0 = wd[`SLCA_B_MODE_HI];
        s_nxt.sm1 = wd[`SLCA_B_MODE_LO];
        s_nxt.sm2 = wd[`SLCA_B_MPE];
        s_nxt.ren = wd[`SLCA_B_REN];
        s_nxt.tb8 = wd[`SLCA_B_TB8];
        s_nxt.rb8 = wd[`SLCA_B_RB8];
        s_nxt.ti  = wd[`SLCA_B_TI];  // [RL8]
        s_nxt.ri  = wd[`SLCA_B_RI];  // [RL9]
      end
      if (hit(idx, `SLCA_IDX_DATA)) begin
        s_nxt.tx_buf  = wd;   // [RL10]
        s_nxt.tx_pend = 1'b1; // [RL15]
      end
      if (hit(idx, `SLCA_IDX_IEN)) begin
        s_nxt.ea = wd[`SLCA_B_EA];
        s_nxt.es = wd[`SLCA_B_ES];
      end
      if (hit(idx, `SLCA_IDX_STATION_ADDRESS))
        s_nxt.station_address = wd;
      if (hit(idx, `SLCA_IDX_SMASK))
        s_nxt.smask = wd;
      if (hit(idx, `SLCA_IDX_AUX)) begin
        s_nxt.fe_sel = wd[`SLCA_B_FESEL];
        s_nxt.dbl    = wd[`SLCA_B_DBL];
      end
      if (hit(idx, `SLCA_IDX_EVEN))
        s_nxt.evt_en = wd[3:0];
      if (hit(idx, `SLCA_IDX_EVCLR))
        s_nxt.evt_st = s_r.evt_st & ~wd[3:0];
    end

    // Transmit engine; in mode 0 it also drives the shift clock for reception
    case (s_r.tx_st)
      SLCA_TX_IDLE: begin
        s_nxt.tx_bit  = 4'h0;
        s_nxt.tx_tick = 4'h0;
        // Start on a tick so the first bit or half clock has its full length
        if (s_r.tx_pend && tick) begin
          s_nxt.tx_pend = 1'b0;
          s_nxt.m0_rx   = 1'b0;
          if (m0) begin
            s_nxt.tx_st  = SLCA_TX_SYNC;
            s_nxt.tx_sh  = {3'b000, s_r.tx_buf};
            s_nxt.sc     = 1'b0;
            s_nxt.txd    = 1'b0;           // [RL16]
            s_nxt.rxd_o  = s_r.tx_buf[0];  // [RL16]
            s_nxt.rxd_oe = 1'b1;
          end else begin
            s_nxt.tx_st = SLCA_TX_ASYNC;
            // Start bit, data LSB first, ninth bit in 11-bit modes, then stop
            s_nxt.tx_sh = m23 ? {1'b1, s_r.tb8, s_r.tx_buf, 1'b0}  // [RL6]
                              : {2'b11, s_r.tx_buf, 1'b0};
            s_nxt.txd   = 1'b0;
          end
        end else if (m0 && tick && !s_r.tx_pend && s_r.ren && !s_r.ri && s_r.rx_st == SLCA_RX_IDLE) begin
          // Mode 0 reception runs while enabled and the previous byte was taken
          s_nxt.tx_st  = SLCA_TX_SYNC; // [RL5]
          s_nxt.m0_rx  = 1'b1;
          s_nxt.rx_sh  = 9'h000;
          s_nxt.sc     = 1'b0;
          s_nxt.txd    = 1'b0;
          s_nxt.rxd_oe = 1'b0;
        end
      end
      SLCA_TX_ASYNC: begin
        if (tick) begin
          s_nxt.tx_tick = s_r.tx_tick + 4'h1;
          if (s_r.tx_tick == 4'hF) begin
            if (s_r.tx_bit == last_bit) begin
              s_nxt.tx_st = SLCA_TX_IDLE;
              s_nxt.txd   = 1'b1;
            end else begin
              s_nxt.tx_bit = s_r.tx_bit + 4'h1;
              s_nxt.tx_sh  = {1'b1, s_r.tx_sh[10:1]};
              s_nxt.txd    = s_r.tx_sh[1];
              // Done flag raised as the stop bit begins
              if (s_r.tx_bit + 4'h1 == last_bit) begin
                s_nxt.ti      = 1'b1; // [RL8]
                ev[`SLCA_EV_TX] = 1'b1;
              end
            end
          end
        end
      end
      SLCA_TX_SYNC: begin
        if (tick) begin
          if (!s_r.sc) begin
            // Rising shift clock; the far end holds data stable here
            s_nxt.sc  = 1'b1;
            s_nxt.txd = 1'b1; // [RL16]
            if (s_r.m0_rx)
              s_nxt.rx_sh = {I_RXD, s_r.rx_sh[8:1]}; // [RL16]
          end else begin
            s_nxt.sc = 1'b0;
            if (s_r.tx_bit == 4'd7) begin
              // End of the eighth bit time
              s_nxt.tx_st  = SLCA_TX_IDLE;
              s_nxt.txd    = 1'b1;
              s_nxt.rxd_oe = 1'b0;
              if (s_r.m0_rx) begin
                s_nxt.ri     = 1'b1;             // [RL9]
                s_nxt.rx_buf = s_r.rx_sh[8:1];   // [RL10]
                ev[`SLCA_EV_RX] = 1'b1;
              end else begin
                s_nxt.ti = 1'b1;                 // [RL8]
                ev[`SLCA_EV_TX] = 1'b1;
              end
            end else begin
              s_nxt.tx_bit = s_r.tx_bit + 4'h1;
              s_nxt.txd    = 1'b0;
              s_nxt.tx_sh  = {1'b0, s_r.tx_sh[10:1]};
              s_nxt.rxd_o  = s_r.tx_sh[1];       // [RL16]
            end
          end
        end
        // Receive enable dropped aborts a mode 0 reception
        if (s_r.m0_rx && !s_r.ren) begin
          s_nxt.tx_st = SLCA_TX_IDLE; // [RL5]
          s_nxt.txd   = 1'b1;
        end
      end
      default: begin
        s_nxt.tx_st = SLCA_TX_IDLE;
        s_nxt.txd   = 1'b1;
      end
    endcase

    // Asynchronous receiver, oversampled at sixteen ticks per bit
    case (s_r.rx_st)
      SLCA_RX_IDLE: begin
        s_nxt.rx_tick = 4'h0;
        s_nxt.rx_bit  = 4'h0;
        if (s_r.ren && !m0 && s_r.rxd_prev && !I_RXD) begin
          s_nxt.rx_st = SLCA_RX_RUN; // [RL5]
          s_nxt.rx_sh = 9'h000;
        end
      end
      SLCA_RX_RUN: begin
        if (!s_r.ren || m0) begin
          // Disabling reception drops the frame in flight
          s_nxt.rx_st = SLCA_RX_IDLE; // [RL5]
        end else if (tick) begin
          s_nxt.rx_tick = s_r.rx_tick + 4'h1;
          if (s_r.rx_tick == 4'hF)
            s_nxt.rx_bit = s_r.rx_bit + 4'h1;
          if (s_r.rx_tick == 4'h7) begin
            if (s_r.rx_bit == 4'h0) begin
              // Glitch rather than a start bit
              if (I_RXD)
                s_nxt.rx_st = SLCA_RX_IDLE;
            end else if (s_r.rx_bit == last_bit) begin
              // Mid stop bit: decide the frame, line watched for the next start
              s_nxt.rx_st = SLCA_RX_IDLE;
              if (!I_RXD) begin
                s_nxt.fe = 1'b1; // [RL14]
                ev[`SLCA_EV_FE] = 1'b1;
              end
              if (m23 && rx_ninth && adr_ok)
                ev[`SLCA_EV_ADR] = 1'b1; // [RL12]
              if (rx_ok) begin
                s_nxt.ri     = 1'b1;     // [RL9]
                s_nxt.rx_buf = rx_data;  // [RL10]
                ev[`SLCA_EV_RX] = 1'b1;
                if (m23 || !s_r.sm2)
                  s_nxt.rb8 = rx_ninth;  // [RL7]
              end
            end else begin
              s_nxt.rx_sh = {I_RXD, s_r.rx_sh[8:1]};
            end
          end
        end
      end
      default: s_nxt.rx_st = SLCA_RX_IDLE;
    endcase

    // Sticky events, set beats a clear in the same cycle
    s_nxt.evt_st = s_nxt.evt_st | ev;

    // Interrupt needs the global enable; serial flags need the serial enable too
    s_nxt.irq = s_nxt.ea & ((s_nxt.es & (s_nxt.ti | s_nxt.ri))  // [RL13] [RL15]
                            | (|(s_nxt.evt_st & s_nxt.evt_en)));
  end

  // All state in one register; idle lines sit high
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      s_r          <= '0;
      s_r.txd      <= 1'b1;
      s_r.rxd_o    <= 1'b1;
      s_r.rxd_prev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign O_WB_DAT = {24'h000000, s_r.rdat};
  assign O_WB_ACK = s_r.ack;
  assign O_TXD    = s_r.txd;
  assign O_RXD    = s_r.rxd_o;
  assign O_RXD_OE = s_r.rxd_oe;
  assign O_IRQ    = s_r.irq;

endmodule
